// *** pkg/capture_pkg.sv ***
/*
  Shared constants and carrier types for the parallel video capture port:
  register offsets, control field layout, reset values, timing counts,
  capture modes, component tags and the structs that travel between files.
  Assumes a 10 MHz register-side clock and a separate pixel clock.
*/
package capture_pkg;

  // Register offsets on the plain register port (byte addresses)
  localparam logic [3:0] CTRL_OFS = 4'h0;
  localparam logic [3:0] HLEN_OFS = 4'h4;
  localparam logic [3:0] VLEN_OFS = 4'h8;
  localparam logic [3:0] STAT_OFS = 4'hC;

  // Status field positions
  localparam int STAT_FIELD_BIT = 0;
  localparam int STAT_OVR_BIT = 1;
  localparam int STAT_FRAMES_LSB = 16;

  // Reset values of the master timing registers, in register clock cycles / lines
  localparam logic [15:0] HLEN_RST = 16'h0100;
  localparam logic [15:0] VLEN_RST = 16'h0020;

  // Width of the generated line sync pulse in register clock cycles
  localparam logic [15:0] SYNC_PULSE_CYCLES = 16'h0004;

  // Input data format selection
  typedef enum logic [1:0] {
    MODE_RAW = 2'b00,
    MODE_YCC16 = 2'b01,
    MODE_YCC8 = 2'b10,
    MODE_DUAL8 = 2'b11
  } mode_t;

  // Tag of a delivered byte lane; COMP_RAW also marks an unused lane
  typedef enum logic [1:0] {
    COMP_Y = 2'b00,
    COMP_CB = 2'b01,
    COMP_CR = 2'b10,
    COMP_RAW = 2'b11
  } comp_t;

  // Control register layout, least significant field last
  typedef struct packed {
    logic enable;
    logic neg_edge;
    logic two_field;
    logic pin_is_field;
    logic master;
    logic upper_half;
    logic [1:0] order8;
    logic cr_first;
    mode_t mode;
  } cfg_t;

  localparam int CTRL_W = $bits(cfg_t);
  localparam cfg_t CTRL_RST = '0;

  // One pixel-clock sample of all capture pins
  typedef struct packed {
    logic [7:0] chroma;
    logic [7:0] luma;
    logic hd;
    logic vd;
    logic wf;
  } cap_word_t;

  // A sample as it crosses into the register clock domain
  typedef struct packed {
    logic dropped;
    cap_word_t word;
  } xfer_t;

  // Assembled sample handed downstream
  typedef struct packed {
    logic valid;
    logic [15:0] data;
    comp_t tag_hi;
    comp_t tag_lo;
    logic line_start;
    logic frame_start;
    logic field;
  } pix_out_t;

endpackage

// *** hdl/sample_crossing.sv ***
/*
  Toggle handshake that carries one word at a time from the pixel clock
  domain into the register clock domain.
  Assumes the source holds nothing: the word is latched here on acceptance.
*/
`timescale 1ns/10ps
`default_nettype none

module sample_crossing #(
  parameter int W = 20
) (
  input wire logic src_clk,
  input wire logic src_rst_n,
  input wire logic src_valid,
  output logic src_ready,
  input wire logic [W-1:0] src_data,
  input wire logic dst_clk,
  input wire logic dst_rst_n,
  input wire logic dst_ce,
  output logic dst_valid,
  output logic [W-1:0] dst_data
);

  // Source side state: request toggle, synchronised acknowledge, held word
  typedef struct packed {
    logic req;
    logic ack1;
    logic ack2;
    logic [W-1:0] data;
  } src_state_t;

  // Destination side state: synchronised request, acknowledge, output word
  typedef struct packed {
    logic req1;
    logic req2;
    logic ack;
    logic valid;
    logic [W-1:0] data;
  } dst_state_t;

  src_state_t s_reg;
  src_state_t s_next;
  dst_state_t d_reg;
  dst_state_t d_next;

  // Idle when the acknowledge has caught up with the request
  assign src_ready = (s_reg.req == s_reg.ack2);
  assign dst_valid = d_reg.valid;
  assign dst_data = d_reg.data;

  // Source: latch the word and toggle the request when idle
  always_comb begin
    s_next = s_reg;
    s_next.ack1 = d_reg.ack;
    s_next.ack2 = s_reg.ack1;
    if (src_valid && src_ready) begin
      s_next.data = src_data;
      s_next.req = ~s_reg.req;
    end
  end

  always_ff @(posedge src_clk) begin
    if (!src_rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // Destination: the held word is stable by the time the request toggle is seen
  always_comb begin
    d_next = d_reg;
    d_next.req1 = s_reg.req;
    d_next.req2 = d_reg.req1;
    d_next.valid = 1'b0;
    if (d_reg.req2 != d_reg.ack) begin
      d_next.data = s_reg.data;
      d_next.valid = 1'b1;
      d_next.ack = d_reg.req2;
    end
  end

  // Clock enable freezes the destination side, so no word is lost while low
  always_ff @(posedge dst_clk) begin
    if (!dst_rst_n) begin
      d_reg <= '0;
    end else if (dst_ce) begin
      d_reg <= d_next;
    end
  end

endmodule

`default_nettype wire

// *** hdl/sensor_capture_controller.sv ***
/*
  Parallel image input port: samples chroma and luma lines, line and
  frame sync and the shared write-gate/field pin on the pixel clock,
  moves each sample the crossing accepts into the register clock domain and assembles raw,
  16-bit or 8-bit multiplexed luma/chroma samples; can generate the
  syncs itself in master mode.
  Assumes a 10 MHz ref_clk, a free pixel clock from the source while
  capturing, and a register master that follows the plain port timing.
*/
// Function
// - Raw sample: luma 0-7, chroma 0-5 above
// - 16-bit: luma bus, alternating chroma, order set
// - 8-bit: multiplexed on one half, order set
// - Two 8-bit streams on both halves at once
// - Line sync marks line start; master drives it
// - Frame sync marks frame start; master drives it
// - Write gate passes data only while high
// - Field id tracks interlaced fields, one or two
// - Pixel clock strobes all data lines
`timescale 1ns/10ps
`default_nettype none

module sensor_capture_controller (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic pixel_clk,
  input wire logic [7:0] chroma_in_bus,
  input wire logic [7:0] luma_in_bus,
  input wire logic line_sync_i,
  output logic line_sync_o,
  output logic line_sync_oe,
  input wire logic frame_sync_i,
  output logic frame_sync_o,
  output logic frame_sync_oe,
  input wire logic write_gate_or_field_id,
  output capture_pkg::pix_out_t pix_out
);
  import capture_pkg::*;

  // Register clock domain state
  typedef struct packed {
    cfg_t ctrl;
    logic [15:0] hlen;
    logic [15:0] vlen;
    logic [15:0] hcnt;
    logic [15:0] vcnt;
    logic hd_o;
    logic vd_o;
    logic hd_prev;
    logic vd_prev;
    logic line_pend;
    logic frame_pend;
    logic [1:0] ph8;
    logic ph16;
    logic field;
    logic overrun;
    logic [15:0] frames;
    logic [31:0] rdata;
    pix_out_t out;
  } ref_state_t;

  // Pixel clock domain state
  typedef struct packed {
    logic rst1;
    logic rst2;
    logic [1:0] cfg1;
    logic [1:0] cfg2;
    cap_word_t pos1;
    cap_word_t pos2;
    cap_word_t neg2;
    logic drop;
  } pix_state_t;

  ref_state_t st_reg;
  ref_state_t st_next;
  pix_state_t px_reg;
  pix_state_t px_next;
  cap_word_t neg1_reg; // Falling-edge capture of the pins
  cap_word_t pins; // All capture pins as one word
  cap_word_t sel_word; // Word from the configured edge
  xfer_t src_word; // Word offered to the crossing
  xfer_t dst_word; // Word arriving in the register domain
  logic src_ready; // Crossing idle
  logic dst_valid; // One-cycle pulse per arriving word
  logic px_enable; // Synchronised enable in the pixel domain
  logic px_neg_edge; // Synchronised edge choice in the pixel domain

  // Tag of an 8-bit multiplexed sample from its order and position in the group of four
  function automatic comp_t comp8(input logic [1:0] order, input logic [1:0] ph);
    comp_t c;
    c = COMP_Y;
    // Orders 0 and 1 put chroma on even positions, 2 and 3 on odd ones
    if (ph[0] == order[1]) begin
      c = (ph[1] ^ order[0]) ? COMP_CR : COMP_CB;
    end
    return c;
  endfunction

  // Outputs straight from registers
  assign rdata = st_reg.rdata;
  assign line_sync_o = st_reg.hd_o;
  assign frame_sync_o = st_reg.vd_o;
  assign line_sync_oe = st_reg.ctrl.master;
  assign frame_sync_oe = st_reg.ctrl.master;
  assign pix_out = st_reg.out;

  // Pin word; the pixel clock is the only strobe for the data lines
  assign pins = '{chroma: chroma_in_bus, luma: luma_in_bus, hd: line_sync_i,
                  vd: frame_sync_i, wf: write_gate_or_field_id};

  assign px_enable = px_reg.cfg2[1];
  assign px_neg_edge = px_reg.cfg2[0];

  // Choose the falling or rising edge copy; both have passed two flops here
  assign sel_word = px_neg_edge ? px_reg.neg2 : px_reg.pos2;
  assign src_word = '{dropped: px_reg.drop, word: sel_word};

  // Falling-edge capture; plain data flop, no reset needed
  always_ff @(negedge pixel_clk) begin
    neg1_reg <= pins;
  end

  // Pixel domain: reset and control synchronisers, second capture stage, drop tracking
  always_comb begin
    px_next = px_reg;
    // Reset release is brought into this domain through two flops
    px_next.rst1 = nrst;
    px_next.rst2 = px_reg.rst1;
    px_next.cfg1 = {st_reg.ctrl.enable, st_reg.ctrl.neg_edge};
    px_next.cfg2 = px_reg.cfg1;
    px_next.pos1 = pins;
    px_next.pos2 = px_reg.pos1;
    px_next.neg2 = neg1_reg;
    // A sample refused by a busy crossing is remembered and reported with the next one
    if (px_enable) begin
      px_next.drop = !src_ready;
    end
    if (!px_reg.rst2) begin
      px_next.cfg1 = '0;
      px_next.cfg2 = '0;
      px_next.drop = 1'b0;
    end
  end

  // Pixel clock may stop outside frames; the last sample still needs two more edges to reach the crossing
  always_ff @(posedge pixel_clk) begin
    px_reg <= px_next;
  end

  // Word-wide handshake into the register domain
  sample_crossing #(
    .W($bits(xfer_t))
  ) u_crossing (
    .src_clk(pixel_clk),
    .src_rst_n(px_reg.rst2),
    .src_valid(px_enable),
    .src_ready(src_ready),
    .src_data(src_word),
    .dst_clk(ref_clk),
    .dst_rst_n(nrst),
    .dst_ce(ce),
    .dst_valid(dst_valid),
    .dst_data(dst_word)
  );

  // Register domain: register port, master sync generator and sample assembly
  always_comb begin
    logic gen_run;
    logic ls;
    logic fs;
    logic gate;
    logic [1:0] ph8;
    logic ph16;
    cap_word_t w;
    gen_run = 1'b0;
    ls = 1'b0;
    fs = 1'b0;
    gate = 1'b0;
    ph8 = 2'b00;
    ph16 = 1'b0;
    w = dst_word.word;
    st_next = st_reg;
    // Pulses and read data last one cycle only
    st_next.rdata = '0;
    st_next.out.valid = 1'b0;
    st_next.out.line_start = 1'b0;
    st_next.out.frame_start = 1'b0;

    // Register writes; unmapped offsets are ignored
    if (wr) begin
      case (addr)
        CTRL_OFS: begin
          st_next.ctrl = cfg_t'(wdata[CTRL_W-1:0]);
        end
        HLEN_OFS: begin
          st_next.hlen = wdata[15:0];
        end
        VLEN_OFS: begin
          st_next.vlen = wdata[15:0];
        end
        STAT_OFS: begin
          // Writing one clears the overrun flag
          if (wdata[STAT_OVR_BIT]) begin
            st_next.overrun = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads; unmapped offsets read as zero
    if (rd) begin
      case (addr)
        CTRL_OFS: begin
          st_next.rdata = 32'(st_reg.ctrl);
        end
        HLEN_OFS: begin
          st_next.rdata = {16'h0000, st_reg.hlen};
        end
        VLEN_OFS: begin
          st_next.rdata = {16'h0000, st_reg.vlen};
        end
        STAT_OFS: begin
          st_next.rdata[STAT_FIELD_BIT] = st_reg.field;
          st_next.rdata[STAT_OVR_BIT] = st_reg.overrun;
          st_next.rdata[STAT_FRAMES_LSB +: 16] = st_reg.frames;
        end
        default: begin
          st_next.rdata = '0;
        end
      endcase
    end

    // Master mode: line and frame syncs counted out of the register clock
    gen_run = st_reg.ctrl.master && st_reg.ctrl.enable;
    if (!gen_run) begin
      st_next.hcnt = '0;
      st_next.vcnt = '0;
      st_next.hd_o = 1'b0;
      st_next.vd_o = 1'b0;
    end else begin
      if (st_reg.hcnt >= 16'(st_reg.hlen - 16'h0001)) begin
        st_next.hcnt = '0;
        if (st_reg.vcnt >= 16'(st_reg.vlen - 16'h0001)) begin
          st_next.vcnt = '0;
        end else begin
          st_next.vcnt = 16'(st_reg.vcnt + 16'h0001);
        end
      end else begin
        st_next.hcnt = 16'(st_reg.hcnt + 16'h0001);
      end
      st_next.hd_o = (st_next.hcnt < SYNC_PULSE_CYCLES);
      st_next.vd_o = (st_next.vcnt == 16'h0000);
    end

    // Arriving sample
    if (dst_valid) begin
      // Line and frame start: own syncs in master mode, sampled pins in slave mode
      if (st_reg.ctrl.master) begin
        ls = st_reg.line_pend;
        fs = st_reg.frame_pend;
      end else begin
        ls = w.hd && !st_reg.hd_prev;
        fs = w.vd && !st_reg.vd_prev;
      end
      st_next.hd_prev = w.hd;
      st_next.vd_prev = w.vd;
      st_next.line_pend = 1'b0;
      st_next.frame_pend = 1'b0;

      // Shared pin: field id or write gate
      if (st_reg.ctrl.pin_is_field) begin
        // A one-field sensor always reports field zero
        st_next.field = st_reg.ctrl.two_field && w.wf;
        gate = 1'b1;
      end else begin
        gate = w.wf;
      end

      // Component positions restart at every line
      ph8 = ls ? 2'b00 : st_reg.ph8;
      ph16 = ls ? 1'b0 : st_reg.ph16;
      st_next.ph8 = 2'(ph8 + 2'b01);
      st_next.ph16 = ~ph16;

      case (st_reg.ctrl.mode)
        MODE_RAW: begin
          // Chroma lines 6 and 7 carry nothing in raw mode
          st_next.out.data = {2'b00, w.chroma[5:0], w.luma};
          st_next.out.tag_hi = COMP_RAW;
          st_next.out.tag_lo = COMP_RAW;
        end
        MODE_YCC16: begin
          st_next.out.data = {w.chroma, w.luma};
          st_next.out.tag_hi = (st_reg.ctrl.cr_first ^ ph16) ? COMP_CR : COMP_CB;
          st_next.out.tag_lo = COMP_Y;
        end
        MODE_YCC8: begin
          // Only the selected half carries data; the other lane reads zero
          if (st_reg.ctrl.upper_half) begin
            st_next.out.data = {w.chroma, 8'h00};
            st_next.out.tag_hi = comp8(st_reg.ctrl.order8, ph8);
            st_next.out.tag_lo = COMP_RAW;
          end else begin
            st_next.out.data = {8'h00, w.luma};
            st_next.out.tag_hi = COMP_RAW;
            st_next.out.tag_lo = comp8(st_reg.ctrl.order8, ph8);
          end
        end
        MODE_DUAL8: begin
          // Two independent decoder streams, one per bus half, same order
          st_next.out.data = {w.chroma, w.luma};
          st_next.out.tag_hi = comp8(st_reg.ctrl.order8, ph8);
          st_next.out.tag_lo = comp8(st_reg.ctrl.order8, ph8);
        end
        default: begin
          st_next.out.data = '0;
          st_next.out.tag_hi = COMP_RAW;
          st_next.out.tag_lo = COMP_RAW;
        end
      endcase

      // Data leave only while enabled and the gate allows it
      st_next.out.valid = st_reg.ctrl.enable && gate;
      st_next.out.line_start = st_reg.ctrl.enable && ls;
      st_next.out.frame_start = st_reg.ctrl.enable && fs;
      st_next.out.field = st_next.field;
      if (st_reg.ctrl.enable && fs) begin
        st_next.frames = 16'(st_reg.frames + 16'h0001);
      end
      // Overrun is set after the software clear, so a new loss is never missed
      if (dst_word.dropped) begin
        st_next.overrun = 1'b1;
      end
    end

    // Generator edges wait for the next sample; set after the clear above wins
    if (st_next.hd_o && !st_reg.hd_o) begin
      st_next.line_pend = 1'b1;
    end
    if (st_next.vd_o && !st_reg.vd_o) begin
      st_next.frame_pend = 1'b1;
    end
  end

  // Register domain flops; clock enable freezes everything
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_reg <= '0;
      st_reg.ctrl <= CTRL_RST;
      st_reg.hlen <= HLEN_RST;
      st_reg.vlen <= VLEN_RST;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

endmodule

`default_nettype wire

// *** tb/capture_properties.sv ***
/* Checker for the capture port: register read timing, sync pin
   drive and output packing. Sees only the top ports; bound below. */
`timescale 1ns/10ps
`default_nettype none
module capture_properties (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [3:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic line_sync_o,
  input wire logic line_sync_oe,
  input wire logic frame_sync_o,
  input wire logic frame_sync_oe,
  input wire capture_pkg::pix_out_t pix_out
);
  import capture_pkg::*;
  cfg_t cfg_reg; // Shadow of the control register
  logic [5:0] age_reg; // Cycles since the last control write
  logic settled; // Old samples have drained after a change
  // Mirror control writes; samples in flight may predate them
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cfg_reg <= CTRL_RST;
      age_reg <= 6'h00;
    end else if (wr && addr == CTRL_OFS) begin
      cfg_reg <= cfg_t'(wdata[CTRL_W-1:0]);
      age_reg <= 6'h00;
    end else if (age_reg != 6'h3F) begin
      age_reg <= age_reg + 6'h01;
    end
  end
  assign settled = age_reg > 6'h10 && cfg_reg.enable;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence master_held;
    cfg_reg.master [*3];
  endsequence
  sequence slave_held;
    !cfg_reg.master [*3];
  endsequence
  a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside the answer cycle");
  a_valid_one_cycle: assert property (pix_out.valid |=> !pix_out.valid)
    else $error("sample valid longer than one cycle");
  a_line_start_valid: assert property (pix_out.line_start |-> pix_out.valid)
    else $error("line start without a sample");
  a_frame_start_valid: assert property (pix_out.frame_start |-> pix_out.valid)
    else $error("frame start without a sample");
  a_oe_pins_paired: assert property (line_sync_oe == frame_sync_oe)
    else $error("sync enables differ");
  a_oe_master_on: assert property (master_held |-> line_sync_oe)
    else $error("master mode does not drive the line sync");
  a_slave_quiet: assert property (slave_held |-> !line_sync_oe && !line_sync_o && !frame_sync_o)
    else $error("slave mode drives a sync");
  a_raw_packing: assert property (settled && cfg_reg.mode == MODE_RAW && pix_out.valid
    |-> pix_out.data[15:14] == 2'b00)
    else $error("raw sample uses chroma bits 6 or 7");
  a_ycc16_tags: assert property (settled && cfg_reg.mode == MODE_YCC16 && pix_out.valid
    |-> pix_out.tag_lo == COMP_Y && pix_out.tag_hi inside {COMP_CB, COMP_CR})
    else $error("16-bit sample tags wrong");
  a_ycc8_unused: assert property (settled && cfg_reg.mode == MODE_YCC8 && pix_out.valid
    |-> (cfg_reg.upper_half ? pix_out.data[7:0] == 8'h00 && pix_out.tag_lo == COMP_RAW
    : pix_out.data[15:8] == 8'h00 && pix_out.tag_hi == COMP_RAW))
    else $error("8-bit sample on the wrong half");
  a_field_single: assert property (settled && !cfg_reg.two_field && pix_out.valid |-> !pix_out.field)
    else $error("field set for a single-field source");
endmodule
bind sensor_capture_controller capture_properties u_props (.ref_clk(ref_clk), .nrst(nrst), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .line_sync_o(line_sync_o), .line_sync_oe(line_sync_oe),
  .frame_sync_o(frame_sync_o), .frame_sync_oe(frame_sync_oe), .pix_out(pix_out));
`default_nettype wire

// *** tb/sensor_source_model.sv ***
/* Image source: free pixel clock and the capture pins.
   Assumes the bench says which pin values to present. */
`timescale 1ns/10ps
`default_nettype none
module sensor_source_model (
  input wire logic launch_rise,
  input wire capture_pkg::cap_word_t want,
  output logic pixel_clk,
  output capture_pkg::cap_word_t pins
);
  import capture_pkg::*;
  // 64 ns clock, offset so it drifts against the register clock
  initial begin
    pixel_clk = 1'b0;
    #7;
    forever #32 pixel_clk = ~pixel_clk;
  end
  // Pins move on the edge opposite the sampling edge
  initial pins = '0;
  always @(pixel_clk) begin
    if (pixel_clk == launch_rise) begin
      pins <= want;
    end
  end
endmodule
`default_nettype wire

// *** tb/test_video_frontend_parallel_capture.sv ***
/* Bench for the capture port: registers, each capture mode, gate,
   field and generated syncs. Assumes the source model beside it. */
`timescale 1ns/10ps
`default_nettype none
module test_video_frontend_parallel_capture;
  import capture_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ce = 1'b1; // Register-side clock enable
  logic [31:0] rdata;
  logic pixel_clk;
  logic launch_rise = 1'b0; // Source launches on falling edge
  cap_word_t want = '0; // Pin values asked of the source
  cap_word_t pins;
  logic hs_o, hs_oe, fs_o, fs_oe;
  pix_out_t pix;
  pix_out_t got; // Last captured sample
  int n_mismatch = 0;
  int n_compared = 0;
  always #50 ref_clk = ~ref_clk;
  sensor_source_model u_src (.launch_rise(launch_rise), .want(want), .pixel_clk(pixel_clk), .pins(pins));
  // Sync wires: the device wins while it drives them
  sensor_capture_controller u_dut (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .pixel_clk(pixel_clk), .chroma_in_bus(pins.chroma),
    .luma_in_bus(pins.luma), .line_sync_i(hs_oe ? hs_o : pins.hd), .line_sync_o(hs_o),
    .line_sync_oe(hs_oe), .frame_sync_i(fs_oe ? fs_o : pins.vd), .frame_sync_o(fs_o),
    .frame_sync_oe(fs_oe), .write_gate_or_field_id(pins.wf), .pix_out(pix));
  task automatic test_done;
    if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] view(input pix_out_t p);
    return 32'({p.data, p.tag_hi, p.tag_lo, p.frame_start, p.field});
  endfunction
  function automatic cap_word_t pw(input logic [7:0] c, input logic [7:0] l, input logic [2:0] s);
    return {c, l, s};
  endfunction
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    @(negedge ref_clk);
    check(rdata, e);
    @(posedge ref_clk);
  endtask
  task automatic set_ctrl(input logic [10:0] v);
    wr_reg(CTRL_OFS, {21'h0, v});
  endtask
  // Next sample, or next line start; a hang ends the run
  task automatic wait_pix(input logic ls);
    int i;
    for (i = 0; i < 300; i++) begin
      @(negedge ref_clk);
      if (pix.valid === 1'b1 && (!ls || pix.line_start === 1'b1)) break;
    end
    got = pix;
    if (i == 300) begin
      check(32'h0, 32'h1);
      test_done();
    end
    @(posedge ref_clk);
  endtask
  // Present pins; flush stale words unless a line start is awaited
  task automatic grab(input cap_word_t w, input logic ls);
    want <= w;
    if (!ls) begin
      wait_pix(1'b0);
      wait_pix(1'b0);
    end
    wait_pix(ls);
  endtask
  task automatic t_regs;
    rd_reg(CTRL_OFS, 32'h0);
    rd_reg(HLEN_OFS, 32'(HLEN_RST));
    rd_reg(VLEN_OFS, 32'(VLEN_RST));
    wr_reg(HLEN_OFS, 32'h10);
    wr_reg(VLEN_OFS, 32'h2);
    // A write while the clock enable is low must not land
    ce <= 1'b0;
    wr_reg(HLEN_OFS, 32'h55);
    ce <= 1'b1;
    wr_reg(4'h2, 32'hFFFFFFFF); // Unmapped, ignored
    rd_reg(HLEN_OFS, 32'h10);
    rd_reg(VLEN_OFS, 32'h2);
    rd_reg(4'h2, 32'h0);
  endtask
  // Raw on both edges, gate closed then open
  task automatic t_raw;
    int k;
    for (int e = 0; e < 2; e++) begin
      launch_rise <= e[0];
      set_ctrl({1'b1, e[0], 9'h0});
      grab(pw(8'hFF, 8'h5A, 3'h1), 1'b0);
      check(view(got), 32'({16'h3F5A, COMP_RAW, COMP_RAW, 2'b00}));
      want <= pw(8'hD2, 8'h34, 3'h0);
      repeat (40) @(posedge ref_clk);
      k = 0;
      repeat (200) begin
        @(negedge ref_clk);
        k += int'(pix.valid === 1'b1);
      end
      check(k, 32'h0);
      @(posedge ref_clk);
      grab(pw(8'hD2, 8'h34, 3'h1), 1'b0);
      check(view(got), 32'({16'h1234, COMP_RAW, COMP_RAW, 2'b00}));
    end
    launch_rise <= 1'b0;
  endtask
  task automatic t_field;
    set_ctrl(11'h580); // Two-field, pin is field id
    grab(pw(8'h01, 8'h02, 3'h1), 1'b0);
    check(32'(got.field), 32'h1);
    grab(pw(8'h01, 8'h02, 3'h0), 1'b0);
    check(32'(got.field), 32'h0);
    set_ctrl(11'h480); // Single field
    grab(pw(8'h01, 8'h02, 3'h1), 1'b0);
    check(32'(got.field), 32'h0);
  endtask
  task automatic t_ycc16;
    for (int cr = 0; cr < 2; cr++) begin
      set_ctrl({4'h9, 4'h0, cr[0], 2'h1});
      grab(pw(8'hC3, 8'hA5, 3'h0), 1'b0);
      grab(pw(8'hC3, 8'hA5, 3'h6), 1'b1);
      check(view(got), 32'({16'hC3A5, cr[0] ? COMP_CR : COMP_CB, COMP_Y, 2'b10}));
      wait_pix(1'b0);
      check(32'(got.tag_hi), 32'(cr[0] ? COMP_CB : COMP_CR));
    end
  endtask
  // Status: two frame starts so far; overrun stays set until written with one
  task automatic t_status;
    set_ctrl(11'h0);
    // Let the last word in flight drain so nothing sets overrun again
    repeat (20) @(posedge ref_clk);
    rd_reg(STAT_OFS, 32'h00020002);
    wr_reg(STAT_OFS, 32'h2);
    rd_reg(STAT_OFS, 32'h00020000);
  endtask
  // Every order, both halves; dual streams last
  task automatic t_ycc8;
    comp_t first[4] = '{COMP_CB, COMP_CR, COMP_Y, COMP_Y};
    comp_t second[4] = '{COMP_Y, COMP_Y, COMP_CB, COMP_CR};
    for (int o = 0; o < 4; o++) begin
      set_ctrl({4'h9, 1'b0, o[0], o[1:0], 3'h2});
      grab(pw(8'h3C, 8'h96, 3'h0), 1'b0);
      grab(pw(8'h3C, 8'h96, 3'h4), 1'b1);
      check(view(got), 32'({o[0] ? 16'h3C00 : 16'h0096, o[0] ? first[o] : COMP_RAW,
        o[0] ? COMP_RAW : first[o], 2'b00}));
      wait_pix(1'b0);
      check(32'(o[0] ? got.tag_hi : got.tag_lo), 32'(second[o]));
    end
    set_ctrl({4'h9, 4'h0, 3'h3});
    grab(pw(8'h3C, 8'h96, 3'h0), 1'b0);
    grab(pw(8'h3C, 8'h96, 3'h4), 1'b1);
    check(view(got), 32'({16'h3C96, COMP_CB, COMP_CB, 2'b00}));
  endtask
  // 16-cycle lines, 2 lines a frame: count sync-high cycles over two frames
  task automatic t_master;
    int h;
    int v;
    set_ctrl(11'h4C0);
    repeat (40) @(posedge ref_clk);
    h = 0;
    v = 0;
    repeat (64) begin
      @(negedge ref_clk);
      h += int'(hs_o === 1'b1);
      v += int'(fs_o === 1'b1);
    end
    check({hs_oe, fs_oe}, 32'h3);
    check(h, 32'h4 * 32'(SYNC_PULSE_CYCLES));
    check(v, 32'h20);
    @(posedge ref_clk);
    set_ctrl(11'h480);
    repeat (4) @(posedge ref_clk);
    check({hs_oe, fs_oe}, 32'h0);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    t_regs();
    t_raw();
    t_field();
    t_ycc16();
    t_status();
    t_ycc8();
    t_master();
    test_done();
  end
endmodule
`default_nettype wire
